// ### rtl/tlb_inval_pkg.sv
// package: constants and types for the translation buffer invalidation block
// assumes a 32-bit linear address and 4-Kbyte base pages
package tlb_inval_pkg;
	localparam int ADDR_W        = 32;
	localparam int SMALL_SHIFT   = 12;  // 4-Kbyte page
	localparam int LARGE2_SHIFT  = 21;  // 2-Mbyte page
	localparam int LARGE4_SHIFT  = 22;  // 4-Mbyte page
	localparam int DEF_ENTRIES   = 8;
	localparam int MAX_ENTRIES   = 64;

	typedef enum logic [1:0] {
		PAGE_SMALL  = 2'b00,
		PAGE_LARGE2 = 2'b01,
		PAGE_LARGE4 = 2'b10
	} page_size_t;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_WALK = 2'b01
	} walk_state_t;
endpackage

// ### rtl/tlb_invalidation_control.sv
// translation buffer pair (data and instruction) with invalidation and flush logic
// assumes pipeline commands are one-cycle pulses synchronous to clk_sys; walker answers with walkDone
//
// Functional notes
// - page invalidate without a same-cycle flush clears every entry mapping that address; others stay valid
// - page invalidate clears both buffers, regardless of range-mask alignment bits 21:12
// - management interrupt falling edge (high to low) flushes every entry, global ones included
// - base register write flushes non-global entries; globals kept while global enable set
// - large 2/4-Mbyte entries, including at address 0, coexist with small low entries
`timescale 1ns/10ps
module tlb_invalidation_control
	import tlb_inval_pkg::*;
#(
	parameter int ENTRIES = DEF_ENTRIES
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        global_page_enable,
	input  wire logic                        system_mgmt_interrupt_n,
	input  wire logic                        invalidate_page_instr,
	input  wire logic [tlb_inval_pkg::ADDR_W-1:0] invalAddr,
	input  wire logic                        writeBaseReg,
	input  wire logic [9:0]                  rangeMaskLow,
	input  wire logic                        lookupValid,
	input  wire logic                        lookupIsFetch,
	input  wire logic [tlb_inval_pkg::ADDR_W-1:0] lookupAddr,
	input  wire logic                        walkDone,
	input  wire logic [tlb_inval_pkg::ADDR_W-1:0] walkFrame,
	input  wire tlb_inval_pkg::page_size_t   walkSize,
	input  wire logic                        walkGlobal,
	output logic                             lookupHit,
	output logic [tlb_inval_pkg::ADDR_W-1:0] physAddr_r,
	output logic                             walkReq,
	output logic [tlb_inval_pkg::ADDR_W-1:0] walkAddr_r,
	output logic                             walkIsFetch_r
);
	import tlb_inval_pkg::*;

	// refuse sizes that the victim counter and index width cannot serve
	if (ENTRIES < 2 || ENTRIES > MAX_ENTRIES) begin : g_bad_entries
		$error("ENTRIES out of range");
	end

	localparam int IDX_W = $clog2(ENTRIES);

	////////////////////////////////////////////////////////////////
	// entry storage: index 0 is the data buffer, 1 the instruction buffer
	logic [1:0][ENTRIES-1:0]             valid_r;
	logic [1:0][ENTRIES-1:0]             glob_r;
	logic [1:0][ENTRIES-1:0][ADDR_W-1:0] tag_r;
	logic [1:0][ENTRIES-1:0][ADDR_W-1:0] frame_r;
	page_size_t [1:0][ENTRIES-1:0]       size_r;
	logic [1:0][IDX_W-1:0]               victim_r;
	walk_state_t                         state_r;
	logic                                smiPrev_r;

	wire smiEdge   = ~system_mgmt_interrupt_n & smiPrev_r;
	wire flushAll  = smiEdge;
	wire flushBase = writeBaseReg;
	wire selFetch  = lookupIsFetch;

	logic [1:0][ENTRIES-1:0] lkHit;
	logic [1:0][ENTRIES-1:0] invHit;
	logic [1:0][ENTRIES-1:0][ADDR_W-1:0] lkPhys;

	////////////////////////////////////////////////////////////////
	// match per entry; each entry compares on its own page size
	genvar b, e;
	generate
		for (b = 0; b < 2; b++) begin : g_buf
			for (e = 0; e < ENTRIES; e++) begin : g_ent
				wire [ADDR_W-1:0] msk = (size_r[b][e] == PAGE_LARGE4) ? ({ADDR_W{1'b1}} << LARGE4_SHIFT) :
					(size_r[b][e] == PAGE_LARGE2) ? ({ADDR_W{1'b1}} << LARGE2_SHIFT) :
					({ADDR_W{1'b1}} << SMALL_SHIFT);
				assign lkHit[b][e]  = valid_r[b][e] && ((lookupAddr & msk) == (tag_r[b][e] & msk));
				// range-mask bits play no part here, so both buffers clear alike
				assign invHit[b][e] = valid_r[b][e] && ((invalAddr & msk) == (tag_r[b][e] & msk));
				assign lkPhys[b][e] = (frame_r[b][e] & msk) | (lookupAddr & ~msk);
			end
		end
	endgenerate

	logic [ADDR_W-1:0] physSel;
	logic              anyHit;
	always_comb begin
		physSel = '0;
		anyHit  = 1'b0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (lkHit[selFetch][i]) begin
				physSel = lkPhys[selFetch][i];
				anyHit  = 1'b1;
			end
		end
	end

	// any invalidation in flight blocks a hit so the stale translation is never used
	wire busy = flushAll | flushBase | invalidate_page_instr;
	assign lookupHit = lookupValid && anyHit && !busy && state_r == ST_RUN;
	wire missStart = lookupValid && !anyHit && !busy && state_r == ST_RUN;
	assign walkReq = state_r == ST_WALK;
	wire fillBuf = walkIsFetch_r;
	wire unused = ^rangeMaskLow;

	////////////////////////////////////////////////////////////////
	// next valid bits
	logic [1:0][ENTRIES-1:0] validNxt;
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			validNxt[k] = valid_r[k];
			if (flushAll) begin
				validNxt[k] = '0;
			end else if (flushBase) begin
				validNxt[k] = global_page_enable ? (valid_r[k] & glob_r[k]) : '0;
			end else if (invalidate_page_instr) begin
				validNxt[k] = valid_r[k] & ~invHit[k];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			valid_r       <= '0;
			glob_r        <= '0;
			tag_r         <= '0;
			frame_r       <= '0;
			size_r        <= '{default: PAGE_SMALL};
			victim_r      <= '0;
			state_r       <= ST_RUN;
			smiPrev_r     <= 1'b1;
			physAddr_r    <= '0;
			walkAddr_r    <= '0;
			walkIsFetch_r <= 1'b0;
		end else begin
			smiPrev_r <= system_mgmt_interrupt_n;
			valid_r   <= validNxt;
			if (lookupHit) begin
				physAddr_r <= physSel;
			end
			unique case (state_r)
				ST_RUN: begin
					if (missStart) begin
						state_r       <= ST_WALK;
						walkAddr_r    <= lookupAddr;
						walkIsFetch_r <= lookupIsFetch;
					end
				end
				ST_WALK: begin
					if (walkDone) begin
						state_r    <= ST_RUN;
						physAddr_r <= walkFrame;
						// a fill is dropped whole if any invalidation lands in the same cycle,
						// so a surviving victim is never relabelled with the stale translation
						if (!busy) begin
							valid_r[fillBuf][victim_r[fillBuf]] <= 1'b1;
							glob_r[fillBuf][victim_r[fillBuf]]  <= walkGlobal & global_page_enable;
							tag_r[fillBuf][victim_r[fillBuf]]   <= walkAddr_r;
							frame_r[fillBuf][victim_r[fillBuf]] <= walkFrame;
							size_r[fillBuf][victim_r[fillBuf]]  <= walkSize;
							victim_r[fillBuf] <= (victim_r[fillBuf] == IDX_W'(ENTRIES - 1)) ? '0
								: victim_r[fillBuf] + 1'b1;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	a_smi_flush_all: assert property (@(posedge clk_sys) disable iff (rst)
		(smiPrev_r && !system_mgmt_interrupt_n) |=> (valid_r == '0))
		else $error("interrupt flush left entries valid");
	a_base_keeps_glob: assert property (@(posedge clk_sys) disable iff (rst)
		(writeBaseReg && !flushAll && global_page_enable) |=> ((valid_r & ~glob_r) == '0))
		else $error("base write left non-global entry");
	a_base_no_glob: assert property (@(posedge clk_sys) disable iff (rst)
		(writeBaseReg && !global_page_enable) |=> (valid_r == '0))
		else $error("base write kept globals with enable clear");
	a_inval_both: assert property (@(posedge clk_sys) disable iff (rst)
		(invalidate_page_instr && state_r == ST_RUN) |=> ((valid_r & $past(invHit)) == '0))
		else $error("page invalidate missed a buffer");
	a_inval_others: assert property (@(posedge clk_sys) disable iff (rst)
		(invalidate_page_instr && !flushAll && !flushBase && state_r == ST_RUN)
		|=> (valid_r == ($past(valid_r) & ~$past(invHit))))
		else $error("page invalidate disturbed other entries");
	a_miss_walks: assert property (@(posedge clk_sys) disable iff (rst)
		(lookupValid && !anyHit && !busy && state_r == ST_RUN) |=> walkReq)
		else $error("miss did not start walk");
	a_no_hit_busy: assert property (@(posedge clk_sys) disable iff (rst)
		busy |-> !lookupHit)
		else $error("hit during invalidation");
	a_base_glob_kept: assert property (@(posedge clk_sys) disable iff (rst)
		(writeBaseReg && !flushAll && global_page_enable)
		|=> (valid_r == ($past(valid_r) & $past(glob_r))))
		else $error("base write lost a global entry");
	a_inval_no_stale: assert property (@(posedge clk_sys) disable iff (rst)
		(invalidate_page_instr ##1 (lookupValid && lookupAddr == $past(invalAddr)))
		|-> !lookupHit)
		else $error("hit on an address just invalidated");

	////////////////////////////////////////////////////////////////
	// walk handshake and refusals
	a_walk_holds: assert property (@(posedge clk_sys) disable iff (rst)
		(walkReq && !walkDone) |=> walkReq)
		else $error("walk request dropped before answer");
	a_walk_ends: assert property (@(posedge clk_sys) disable iff (rst)
		(walkReq && walkDone) |=> !walkReq)
		else $error("walk request stayed after answer");
	a_walk_addr_held: assert property (@(posedge clk_sys) disable iff (rst)
		(walkReq && !walkDone) |=> $stable(walkAddr_r))
		else $error("walk address moved during walk");
	a_miss_addr: assert property (@(posedge clk_sys) disable iff (rst)
		missStart |=> (walkAddr_r == $past(lookupAddr) && walkIsFetch_r == $past(lookupIsFetch)))
		else $error("walk address or buffer wrong");
	a_refuse_walk: assert property (@(posedge clk_sys) disable iff (rst)
		(busy && !walkReq) |=> !walkReq)
		else $error("walk started during invalidation");
	a_hit_no_walk: assert property (@(posedge clk_sys) disable iff (rst)
		lookupHit |=> !walkReq)
		else $error("hit started a walk");
	a_reset_empty: assert property (@(posedge clk_sys)
		(rst ##1 !rst) |-> (valid_r == '0 && !walkReq && !lookupHit))
		else $error("entries valid after reset");
endmodule

// ### verif/tlb_invalidation_control_bench.sv
// bench: directed scenarios for the translation buffer invalidation block
// assumes the package is compiled first; the bench acts as pipeline and walker
`timescale 1ns/10ps
module tlb_invalidation_control_bench;
	import tlb_inval_pkg::*;
	logic              clk_sys = 0, rst = 1, global_page_enable = 0, system_mgmt_interrupt_n = 1;
	logic              invalidate_page_instr = 0, writeBaseReg = 0, lookupValid = 0, lookupIsFetch = 0;
	logic              walkDone = 0, walkGlobal = 0, lookupHit, walkReq, walkIsFetch_r;
	logic [9:0]        rangeMaskLow = 10'h000;
	logic [ADDR_W-1:0] invalAddr = 0, lookupAddr = 0, walkFrame = 0, physAddr_r, walkAddr_r;
	page_size_t        walkSize = PAGE_SMALL;
	int                bad_count = 0, n_checks = 0;
	tlb_invalidation_control uut (.clk_sys(clk_sys), .rst(rst), .global_page_enable(global_page_enable),
		.system_mgmt_interrupt_n(system_mgmt_interrupt_n), .invalidate_page_instr(invalidate_page_instr),
		.invalAddr(invalAddr), .writeBaseReg(writeBaseReg), .rangeMaskLow(rangeMaskLow),
		.lookupValid(lookupValid), .lookupIsFetch(lookupIsFetch), .lookupAddr(lookupAddr),
		.walkDone(walkDone), .walkFrame(walkFrame), .walkSize(walkSize), .walkGlobal(walkGlobal),
		.lookupHit(lookupHit), .physAddr_r(physAddr_r), .walkReq(walkReq), .walkAddr_r(walkAddr_r),
		.walkIsFetch_r(walkIsFetch_r));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// lookup; on a miss answer the walk with frame p
	task lk(input logic [31:0] a, input logic f, input logic h, input logic [31:0] p);
		@(posedge clk_sys) #1;
		lookupValid = 1;
		lookupAddr = a;
		lookupIsFetch = f;
		#2 check(lookupHit, h);
		@(posedge clk_sys) #1;
		lookupValid = 0;
		if (h) begin
			check(physAddr_r, p);
		end else begin
			check(walkReq, 1);
			check(walkAddr_r, a);
			check(walkIsFetch_r, f);
			walkDone = 1;
			walkFrame = p;
			@(posedge clk_sys) #1;
			walkDone = 0;
			check(walkReq, 0);
			check(physAddr_r, p);
		end
	endtask
	// k: 0 page invalidate, 1 base register write, 2 management interrupt
	task pulse(input int k, input logic [31:0] a);
		@(posedge clk_sys) #1;
		invalAddr = a;
		invalidate_page_instr = (k == 0);
		writeBaseReg = (k == 1);
		system_mgmt_interrupt_n = (k != 2);
		@(posedge clk_sys) #1;
		invalidate_page_instr = 0;
		writeBaseReg = 0;
		system_mgmt_interrupt_n = 1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_page;
		rangeMaskLow = 10'h3ff;
		lk(32'h0040_0000, 0, 0, 32'h1000_0000);
		lk(32'h0040_0000, 1, 0, 32'h2000_0000);
		lk(32'h0040_1000, 0, 0, 32'h3000_0000);
		lk(32'h0040_0000, 1, 1, 32'h2000_0000);
		pulse(0, 32'h0040_0000);
		lk(32'h0040_1000, 0, 1, 32'h3000_0000);
		lk(32'h0040_0000, 1, 0, 32'h4000_0000);
		lk(32'h0040_0000, 0, 0, 32'h5000_0000);
	endtask
	task t_large;
		walkSize = PAGE_SMALL;
		lk(32'h0000_1000, 0, 0, 32'h0900_0000);
		walkSize = PAGE_LARGE4;
		lk(32'h0000_0000, 0, 0, 32'h0800_0000);
		lk(32'h0030_0000, 0, 1, 32'h0830_0000);
		pulse(0, 32'h0020_0000);
		lk(32'h0000_1000, 0, 1, 32'h0900_0000);
		lk(32'h0030_0000, 0, 0, 32'h0a00_0000);
		walkSize = PAGE_SMALL;
		pulse(0, 32'h0000_1000);
		lk(32'h0000_1000, 0, 0, 32'h0b00_0000);
		walkSize = PAGE_LARGE2;
		lk(32'h0120_0000, 0, 0, 32'h0c00_0000);
		lk(32'h013f_f000, 0, 1, 32'h0c1f_f000);
		pulse(0, 32'h0130_0000);
		lk(32'h0120_0000, 0, 0, 32'h0d00_0000);
		walkSize = PAGE_SMALL;
	endtask
	task t_smi;
		global_page_enable = 1;
		walkGlobal = 1;
		lk(32'h0080_0000, 0, 0, 32'h1100_0000);
		lk(32'h0080_0000, 0, 1, 32'h1100_0000);
		pulse(2, 0);
		lk(32'h0080_0000, 0, 0, 32'h1200_0000);
	endtask
	task t_base;
		lk(32'h00c0_0000, 1, 0, 32'h1300_0000);
		walkGlobal = 0;
		lk(32'h00c0_1000, 1, 0, 32'h1400_0000);
		pulse(1, 0);
		lk(32'h00c0_0000, 1, 1, 32'h1300_0000);
		lk(32'h00c0_1000, 1, 0, 32'h1500_0000);
		global_page_enable = 0;
		pulse(1, 0);
		lk(32'h00c0_0000, 1, 0, 32'h1600_0000);
	endtask
	// lookup refused while an invalidation of its own page stands, then retried
	task t_refuse;
		lk(32'h00d0_0000, 0, 0, 32'h1700_0000);
		lk(32'h00d0_0000, 0, 1, 32'h1700_0000);
		@(posedge clk_sys) #1;
		invalAddr = 32'h00d0_0000;
		invalidate_page_instr = 1;
		lookupValid = 1;
		lookupAddr = 32'h00d0_0000;
		lookupIsFetch = 0;
		#2 check(lookupHit, 0);
		@(posedge clk_sys) #1;
		invalidate_page_instr = 0;
		check(walkReq, 0);
		#2 check(lookupHit, 0);
		@(posedge clk_sys) #1;
		lookupValid = 0;
		check(walkReq, 1);
		check(walkAddr_r, 32'h00d0_0000);
		walkDone = 1;
		walkFrame = 32'h1800_0000;
		@(posedge clk_sys) #1;
		walkDone = 0;
		check(walkReq, 0);
		check(physAddr_r, 32'h1800_0000);
		lk(32'h00d0_0000, 0, 1, 32'h1800_0000);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		#1 rst = 0;
		t_page;
		t_large;
		t_smi;
		t_base;
		t_refuse;
		finish_test;
	end
	initial begin
		#20000;
		bad_count++;
		finish_test;
	end
endmodule
